// [logic/cmp_config_ctrl.sv]
// configuration front end: power-on reset, scheme decode, config/init/user sequencing
// assumes pins arrive asynchronously; the data loader sits on the same clock
//
// Contract
// - decode scheme select: 000 fast par, 001 async par, 010 serial, 100/101/110 remote/local.
// - remote/local schemes also sample the remote-versus-local select input.
// - boundary-scan configuration has priority; scheme select is then ignored.
// - done output low from power-up through configuration, high once complete.
// - configuration request driven low pulls done output low again.
// - user pins tri-stated during configuration, enabled only after initialisation.
// - init-done enabled by first-frame option bit drives low once loaded.
// - after loading, initialise, then enter user mode only when initialisation ends.
// - power-on reset delay is 100 ms with select low, 2 ms with it high.
// - status held low after power-up until all supplies pass their trip points.
// - weak pull-ups before and during configuration unless pull-up disable is high; the code holds them off while rstn_i is low.
// - serial scheme captures one data bit on each configuration clock rising edge.
// - on error drive status low, reset internally, restart if auto restart enabled.
`timescale 1ns/1ps
module cmp_config_ctrl
    import cmp_pkg::*;
#(
    parameter int unsigned POR_LONG_CYCLES = POR_LONG_CYC,
    parameter int unsigned POR_SHORT_CYCLES = POR_SHORT_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [2:0] scheme_select_i,
    input wire logic remote_local_select_i,
    input wire logic config_request_n_i,
    input wire logic reset_delay_select_i,
    input wire logic weak_pullup_disable_i,
    input wire logic supplies_ok_i,
    input wire logic jtag_config_i,
    input wire logic config_clock_i,
    input wire logic serial_config_data_i,
    input wire logic config_status_n_i,
    input wire logic load_complete_i,
    input wire logic config_error_i,
    input wire logic option_valid_i,
    input wire logic option_init_done_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    output logic config_done_out_o,
    output logic config_status_n_o,
    output logic config_status_n_oe_o,
    output logic init_done_o,
    output logic init_done_oe_o,
    output logic user_io_enable_o,
    output logic weak_pullup_en_o,
    output logic [2:0] scheme_o,
    output logic remote_update_o,
    output logic jtag_mode_o,
    output logic user_mode_o,
    output logic irq_o
);

    typedef struct packed {
        cmp_fsm_t st;
        logic [POR_CNT_W-1:0] por_cnt;
        logic [7:0] cnt;
        logic [2:0] scheme;
        logic remote;
        logic jtag_mode;
        logic done;
        logic status_drv;
        logic init_done_drv;
        logic init_done_en;
        logic user_io_en;
        logic pullup_en;
        logic auto_restart;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
        logic [15:0] shift;
        logic [15:0] bit_cnt;
        logic clk_prev;
        logic jtag_prev;
    } cmp_state_t;

    localparam logic [POR_CNT_W-1:0] POR_LONG_LIM = POR_CNT_W'(POR_LONG_CYCLES - 1);
    localparam logic [POR_CNT_W-1:0] POR_SHORT_LIM = POR_CNT_W'(POR_SHORT_CYCLES - 1);

    cmp_state_t q;
    cmp_state_t d;

    logic [SYNC_W-1:0] sync_w;
    logic [2:0] s_scheme;
    logic s_remote;
    logic s_req_n;
    logic s_delay_sel;
    logic s_pullup_dis;
    logic s_supply;
    logic s_jtag;
    logic s_config_clock;
    logic s_data;
    logic s_status;

    cmp_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i({scheme_select_i, remote_local_select_i, config_request_n_i,
                  reset_delay_select_i, weak_pullup_disable_i, supplies_ok_i,
                  jtag_config_i, config_clock_i, serial_config_data_i,
                  config_status_n_i}),
        .sync_o(sync_w)
    );

    assign s_scheme = sync_w[11:9];
    assign s_remote = sync_w[8];
    assign s_req_n = sync_w[7];
    assign s_delay_sel = sync_w[6];
    assign s_pullup_dis = sync_w[5];
    assign s_supply = sync_w[4];
    assign s_jtag = sync_w[3];
    assign s_config_clock = sync_w[2];
    assign s_data = sync_w[1];
    assign s_status = sync_w[0];

    function automatic logic scheme_legal(input logic [2:0] code);
        logic ok;
        ok = 1'b0;
        unique case (code)
            SCH_FAST_PARALLEL, SCH_ASYNC_PARALLEL, SCH_SERIAL,
            SCH_RL_FAST_PARALLEL, SCH_RL_ASYNC_PARALLEL, SCH_RL_SERIAL: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    logic clk_rise;
    logic jtag_rise;
    logic start_cfg;
    logic serial_mode;
    logic [POR_CNT_W-1:0] por_lim;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;

    always_comb begin
        d = q;
        d.rdata = '0;
        ev = '0;
        start_cfg = 1'b0;
        w1c = '0;
        clk_rise = s_config_clock & ~q.clk_prev;
        jtag_rise = s_jtag & ~q.jtag_prev;
        d.clk_prev = s_config_clock;
        d.jtag_prev = s_jtag;
        serial_mode = ~q.jtag_mode & ((q.scheme == SCH_SERIAL) | (q.scheme == SCH_RL_SERIAL));
        por_lim = s_delay_sel ? POR_SHORT_LIM : POR_LONG_LIM;

        if (reg_we_i) begin
            unique case (reg_addr_i)
                REG_CTRL: d.auto_restart = reg_wdata_i[CTRL_AUTO_BIT];
                REG_IRQ_STAT: w1c = reg_wdata_i[IRQ_W-1:0];
                REG_IRQ_MASK: d.irq_mask = reg_wdata_i[IRQ_W-1:0];
                default: ;
            endcase
        end

        unique case (q.st)
            CMP_POR: begin
                d.status_drv = 1'b1;
                d.done = 1'b0;
                // the delay only runs once every supply is above its trip point
                if (!s_supply) begin
                    d.por_cnt = '0;
                end else if (q.por_cnt != por_lim) begin
                    d.por_cnt = q.por_cnt + 1'b1;
                end else begin
                    d.status_drv = 1'b0;
                    d.st = CMP_IDLE;
                end
            end
            CMP_IDLE: begin
                // other devices may still hold status low; wait for the wire to rise
                if (s_req_n && s_status) begin
                    start_cfg = 1'b1;
                end
            end
            CMP_CONFIG: begin
                if (serial_mode && clk_rise) begin
                    d.shift = {q.shift[14:0], s_data};
                    d.bit_cnt = q.bit_cnt + 1'b1;
                end
                if (option_valid_i && option_init_done_i) begin
                    d.init_done_en = 1'b1;
                    d.init_done_drv = 1'b1;
                end
                if (config_error_i) begin
                    d.st = CMP_ERROR;
                    d.status_drv = 1'b1;
                    d.cnt = '0;
                    ev[IRQ_ERROR] = 1'b1;
                end else if (load_complete_i) begin
                    d.done = 1'b1;
                    d.st = CMP_INIT;
                    d.cnt = '0;
                    ev[IRQ_DONE] = 1'b1;
                end
            end
            CMP_INIT: begin
                if (q.cnt == INIT_CYCLES - 8'h01) begin
                    d.st = CMP_USER;
                    d.user_io_en = 1'b1;
                    d.init_done_drv = 1'b0;
                    ev[IRQ_USER] = 1'b1;
                end else begin
                    d.cnt = q.cnt + 8'h01;
                end
            end
            CMP_USER: ;
            CMP_ERROR: begin
                d.status_drv = 1'b1;
                d.done = 1'b0;
                if (q.cnt != ERR_HOLD_CYCLES) begin
                    d.cnt = q.cnt + 8'h01;
                end else if (q.auto_restart) begin
                    d.status_drv = 1'b0;
                    d.st = CMP_IDLE;
                end
            end
            default: begin
                d.st = CMP_POR;
                d.por_cnt = '0;
            end
        endcase

        // boundary-scan start overrides any scheme in progress
        if (q.st != CMP_POR && jtag_rise) begin
            d.st = CMP_CONFIG;
            d.jtag_mode = 1'b1;
            d.remote = 1'b0;
            d.done = 1'b0;
            d.user_io_en = 1'b0;
            d.init_done_en = 1'b0;
            d.init_done_drv = 1'b0;
            d.status_drv = 1'b0;
            d.shift = '0;
            d.bit_cnt = '0;
        end else if (start_cfg) begin
            d.jtag_mode = 1'b0;
            d.scheme = s_scheme;
            d.remote = s_scheme[2] & s_remote;
            d.shift = '0;
            d.bit_cnt = '0;
            d.init_done_en = 1'b0;
            d.init_done_drv = 1'b0;
            if (scheme_legal(s_scheme)) begin
                d.st = CMP_CONFIG;
            end else begin
                d.st = CMP_ERROR;
                d.status_drv = 1'b1;
                d.cnt = '0;
                ev[IRQ_ERROR] = 1'b1;
            end
        end

        // a low request returns to idle after power-on reset; scheme, remote and init-done enable keep their values
        if (q.st != CMP_POR && !s_req_n) begin
            d.st = CMP_IDLE;
            d.done = 1'b0;
            d.user_io_en = 1'b0;
            d.init_done_drv = 1'b0;
            d.status_drv = 1'b0;
            d.jtag_mode = 1'b0;
            if (q.st != CMP_IDLE) begin
                ev[IRQ_REQUEST] = 1'b1;
            end
        end

        d.pullup_en = ~d.user_io_en & ~s_pullup_dis;

        // set wins over the write-one clear
        d.irq_stat = (q.irq_stat & ~w1c) | ev;
        d.irq = |(d.irq_stat & d.irq_mask);

        if (reg_re_i) begin
            unique case (reg_addr_i)
                REG_CTRL: d.rdata[CTRL_AUTO_BIT] = q.auto_restart;
                REG_STATE: begin
                    d.rdata[ST_FSM_LSB +: 3] = q.st;
                    d.rdata[ST_SCHEME_LSB +: 3] = q.scheme;
                    d.rdata[ST_REMOTE_BIT] = q.remote;
                    d.rdata[ST_JTAG_BIT] = q.jtag_mode;
                    d.rdata[ST_DONE_BIT] = q.done;
                    d.rdata[ST_INITEN_BIT] = q.init_done_en;
                    d.rdata[ST_USER_BIT] = q.user_io_en;
                    d.rdata[ST_PULLUP_BIT] = q.pullup_en;
                end
                REG_IRQ_STAT: d.rdata[IRQ_W-1:0] = q.irq_stat;
                REG_IRQ_MASK: d.rdata[IRQ_W-1:0] = q.irq_mask;
                REG_SHIFT: begin
                    d.rdata[15:0] = q.shift;
                    d.rdata[SHIFT_CNT_LSB +: 16] = q.bit_cnt;
                end
                default: d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
            q.st <= CMP_POR;
            q.status_drv <= 1'b1;
            q.pullup_en <= 1'b0;
            q.auto_restart <= CTRL_AUTO_RST;
            q.irq_mask <= IRQ_MASK_RST;
        end else begin
            q <= d;
        end
    end

    // open-drain pins: the data level is always low, only the enable moves
    assign reg_rdata_o = q.rdata;
    assign config_done_out_o = q.done;
    assign config_status_n_o = 1'b0;
    assign config_status_n_oe_o = q.status_drv;
    assign init_done_o = 1'b0;
    assign init_done_oe_o = q.init_done_drv;
    assign user_io_enable_o = q.user_io_en;
    assign weak_pullup_en_o = q.pullup_en;
    assign scheme_o = q.scheme;
    assign remote_update_o = q.remote;
    assign jtag_mode_o = q.jtag_mode;
    assign user_mode_o = q.user_io_en;
    assign irq_o = q.irq;

endmodule // cmp_config_ctrl

// [logic/cmp_pkg.sv]
// configuration mode / power-on-reset controller: shared constants and types
// assumes a single 200 MHz clock domain and a plain register port
package cmp_pkg;

    // clock and power-on reset timing
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned POR_LONG_US = 100000;
    localparam int unsigned POR_SHORT_US = 2000;
    localparam int unsigned POR_LONG_CYC = POR_LONG_US * CLK_MHZ;
    localparam int unsigned POR_SHORT_CYC = POR_SHORT_US * CLK_MHZ;
    localparam int unsigned POR_CNT_W = 25;

    // internal initialisation and error hold lengths, in clock cycles
    localparam logic [7:0] INIT_CYCLES = 8'h40;
    localparam logic [7:0] ERR_HOLD_CYCLES = 8'h08;

    // scheme-select encodings
    localparam logic [2:0] SCH_FAST_PARALLEL = 3'h0;
    localparam logic [2:0] SCH_ASYNC_PARALLEL = 3'h1;
    localparam logic [2:0] SCH_SERIAL = 3'h2;
    localparam logic [2:0] SCH_RL_FAST_PARALLEL = 3'h4;
    localparam logic [2:0] SCH_RL_ASYNC_PARALLEL = 3'h5;
    localparam logic [2:0] SCH_RL_SERIAL = 3'h6;

    // register map (byte addresses)
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATE = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_SHIFT = 8'h10;

    // field positions
    localparam int unsigned CTRL_AUTO_BIT = 0;
    localparam int unsigned ST_FSM_LSB = 0;
    localparam int unsigned ST_SCHEME_LSB = 4;
    localparam int unsigned ST_REMOTE_BIT = 8;
    localparam int unsigned ST_JTAG_BIT = 9;
    localparam int unsigned ST_DONE_BIT = 10;
    localparam int unsigned ST_INITEN_BIT = 11;
    localparam int unsigned ST_USER_BIT = 12;
    localparam int unsigned ST_PULLUP_BIT = 13;
    localparam int unsigned SHIFT_CNT_LSB = 16;

    // interrupt sources
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_DONE = 0;
    localparam int unsigned IRQ_USER = 1;
    localparam int unsigned IRQ_ERROR = 2;
    localparam int unsigned IRQ_REQUEST = 3;

    // reset values
    localparam logic CTRL_AUTO_RST = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

    // synchroniser width: scheme(3) remote req delay pullup supply jtag clk data status
    localparam int unsigned SYNC_W = 12;

    typedef enum logic [2:0] {
        CMP_POR = 3'b000,
        CMP_IDLE = 3'b001,
        CMP_CONFIG = 3'b011,
        CMP_INIT = 3'b010,
        CMP_USER = 3'b110,
        CMP_ERROR = 3'b100
    } cmp_fsm_t;

endpackage

// [logic/cmp_sync.sv]
// two-flop synchroniser for a group of independent level inputs
// assumes every bit is a slow level; no bus coherency across bits
`timescale 1ns/1ps
module cmp_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // cmp_sync

// [test/cmp_config_ctrl_sva.sv]
// assertion checker for the configuration controller, bound to its top ports
// assumes one clock domain; loader pulses arrive only while a configuration runs
`timescale 1ns/1ps
module cmp_config_ctrl_sva (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic config_request_n_i,
    input wire logic weak_pullup_disable_i,
    input wire logic supplies_ok_i,
    input wire logic load_complete_i,
    input wire logic config_error_i,
    input wire logic option_valid_i,
    input wire logic option_init_done_i,
    input wire logic config_done_out_o,
    input wire logic config_status_n_o,
    input wire logic config_status_n_oe_o,
    input wire logic init_done_o,
    input wire logic init_done_oe_o,
    input wire logic user_io_enable_o,
    input wire logic weak_pullup_en_o,
    input wire logic [2:0] scheme_o,
    input wire logic remote_update_o,
    input wire logic jtag_mode_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_init_hold;
        (config_done_out_o && !user_io_enable_o) [*8];
    endsequence
    sequence s_err_hold;
        (config_status_n_oe_o && !config_done_out_o) [*8];
    endsequence
    AST_DONE_CAUSE: assert property ($rose(config_done_out_o) |-> $past(load_complete_i))
        else $error("done rose without load complete");
    AST_DONE_REQ: assert property ($fell(config_request_n_i) |-> ##[1:5] !config_done_out_o)
        else $error("done stayed high after request");
    AST_USER_DONE: assert property (user_io_enable_o |-> config_done_out_o)
        else $error("user pins enabled while not configured");
    AST_INIT_HOLD: assert property ($rose(config_done_out_o) |-> s_init_hold)
        else $error("user mode entered before initialisation");
    AST_INIT_DONE: assert property (option_valid_i && option_init_done_i |=>
        init_done_oe_o && !init_done_o)
        else $error("init done not driven low after option");
    AST_POR_SUPPLY: assert property ($fell(config_status_n_oe_o) |-> $past(supplies_ok_i, 3))
        else $error("status released without supplies");
    AST_STATUS_LOW: assert property (config_status_n_oe_o |->
        !config_status_n_o && !config_done_out_o)
        else $error("status driven high");
    AST_PULLUP_ON: assert property ((!weak_pullup_disable_i && !user_io_enable_o) [*4] |->
        weak_pullup_en_o)
        else $error("pull-ups off while enabled");
    AST_PULLUP_OFF: assert property (weak_pullup_disable_i [*4] |-> !weak_pullup_en_o)
        else $error("pull-ups on while disabled");
    AST_ERR_HOLD: assert property (config_error_i |=> s_err_hold)
        else $error("error did not hold status low");
    AST_SCHEME_HOLD: assert property (config_done_out_o && $past(config_done_out_o) |->
        $stable(scheme_o))
        else $error("scheme changed while configured");
    AST_JTAG_LOCAL: assert property (jtag_mode_o |-> !remote_update_o)
        else $error("remote update during boundary-scan");
endmodule // cmp_config_ctrl_sva
bind cmp_config_ctrl cmp_config_ctrl_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i),
    .config_request_n_i(config_request_n_i), .weak_pullup_disable_i(weak_pullup_disable_i),
    .supplies_ok_i(supplies_ok_i), .load_complete_i(load_complete_i),
    .config_error_i(config_error_i), .option_valid_i(option_valid_i),
    .option_init_done_i(option_init_done_i), .config_done_out_o(config_done_out_o),
    .config_status_n_o(config_status_n_o), .config_status_n_oe_o(config_status_n_oe_o),
    .init_done_o(init_done_o), .init_done_oe_o(init_done_oe_o),
    .user_io_enable_o(user_io_enable_o), .weak_pullup_en_o(weak_pullup_en_o),
    .scheme_o(scheme_o), .remote_update_o(remote_update_o), .jtag_mode_o(jtag_mode_o));

// [test/cmp_config_ctrl_test.sv]
// self-checking bench for the configuration controller with a host model
// assumes shortened power-on reset counts; status wire pulled up, driven low by the device
`timescale 1ns/1ps
module cmp_config_ctrl_test;
    import cmp_pkg::*;
    localparam int unsigned LONG_C = 50;
    localparam int unsigned SHORT_C = 10;
    localparam logic [2:0] CODES [6] = '{SCH_FAST_PARALLEL, SCH_ASYNC_PARALLEL, SCH_SERIAL,
        SCH_RL_FAST_PARALLEL, SCH_RL_ASYNC_PARALLEL, SCH_RL_SERIAL};
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic reset_delay_select_i = 1'b0;
    logic weak_pullup_disable_i = 1'b0;
    logic supplies_ok_i = 1'b0;
    logic load_complete_i = 1'b0;
    logic config_error_i = 1'b0;
    logic option_valid_i = 1'b0;
    logic option_init_done_i = 1'b0;
    logic [ADDR_W-1:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    wire logic [2:0] scheme_select_i;
    wire logic remote_local_select_i, config_request_n_i, jtag_config_i;
    wire logic config_clock_i, serial_config_data_i, config_status_n_i;
    logic [31:0] reg_rdata_o;
    logic config_done_out_o, config_status_n_o, config_status_n_oe_o, init_done_o;
    logic init_done_oe_o, user_io_enable_o, weak_pullup_en_o, remote_update_o;
    logic jtag_mode_o, user_mode_o, irq_o;
    logic [2:0] scheme_o;
    int fail_count = 0;
    int compares = 0;
    assign config_status_n_i = ~config_status_n_oe_o;
    always #2.5 clk_i = ~clk_i;
    cmp_host_model host (.clk_i(clk_i), .scheme_select_o(scheme_select_i),
        .remote_local_select_o(remote_local_select_i), .config_request_n_o(config_request_n_i),
        .jtag_config_o(jtag_config_i), .config_clock_o(config_clock_i),
        .serial_config_data_o(serial_config_data_i));
    cmp_config_ctrl #(.POR_LONG_CYCLES(LONG_C), .POR_SHORT_CYCLES(SHORT_C)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .scheme_select_i(scheme_select_i),
        .remote_local_select_i(remote_local_select_i), .config_request_n_i(config_request_n_i),
        .reset_delay_select_i(reset_delay_select_i), .weak_pullup_disable_i(weak_pullup_disable_i),
        .supplies_ok_i(supplies_ok_i), .jtag_config_i(jtag_config_i),
        .config_clock_i(config_clock_i), .serial_config_data_i(serial_config_data_i),
        .config_status_n_i(config_status_n_i), .load_complete_i(load_complete_i),
        .config_error_i(config_error_i), .option_valid_i(option_valid_i),
        .option_init_done_i(option_init_done_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .config_done_out_o(config_done_out_o),
        .config_status_n_o(config_status_n_o), .config_status_n_oe_o(config_status_n_oe_o),
        .init_done_o(init_done_o), .init_done_oe_o(init_done_oe_o),
        .user_io_enable_o(user_io_enable_o), .weak_pullup_en_o(weak_pullup_en_o),
        .scheme_o(scheme_o), .remote_update_o(remote_update_o), .jtag_mode_o(jtag_mode_o),
        .user_mode_o(user_mode_o), .irq_o(irq_o));
    task automatic close_out();
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic wait_st(input logic [2:0] st);
        logic [31:0] d;
        int n;
        n = 0;
        do begin
            rd(REG_STATE, d);
            n++;
        end while (d[2:0] !== st && n < 40);
        if (d[2:0] !== st) begin
            fail_count++;
            close_out();
        end
    endtask
    // which: 0 option frame, 1 load complete, 2 load error
    task automatic pulse(input int which);
        @(posedge clk_i);
        option_valid_i <= (which == 0);
        option_init_done_i <= (which == 0);
        load_complete_i <= (which == 1);
        config_error_i <= (which == 2);
        @(posedge clk_i);
        {option_valid_i, option_init_done_i, load_complete_i, config_error_i} <= 4'h0;
        #1;
    endtask
    task automatic por_run(input logic sel, output int n);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        supplies_ok_i <= 1'b0;
        reset_delay_select_i <= sel;
        repeat (19) @(posedge clk_i);
        rstn_i <= 1'b1;
        cyc(30);
        chk("status_held", config_status_n_oe_o, 1'b1);
        @(posedge clk_i);
        supplies_ok_i <= 1'b1;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (config_status_n_oe_o !== 1'b0 && n < 200);
    endtask
    initial begin
        int n_s, n_l, k;
        logic [31:0] d;
        logic [2:0] code;
        por_run(1'b1, n_s);
        por_run(1'b0, n_l);
        chk("por_delta", n_l - n_s, LONG_C - SHORT_C);
        rd(REG_CTRL, d);
        chk("ctrl_rst", d, 32'h0);
        rd(REG_IRQ_MASK, d);
        chk("mask_rst", d, 32'h0);
        rd(8'h20, d);
        chk("unmapped", d, 32'h0);
        wr(REG_STATE, 32'hFFFFFFFF);
        rd(REG_STATE, d);
        chk("state_ro", d[2:0], CMP_IDLE);
        for (k = 0; k < 6; k++) begin
            code = CODES[k];
            host.start(code, k[0], 1'b0);
            weak_pullup_disable_i <= (k == 3);
            wait_st(CMP_CONFIG);
            rd(REG_STATE, d);
            chk("scheme", d[6:4], code);
            chk("remote", d[8], code[2] & k[0]);
            chk("done_cfg", config_done_out_o, 1'b0);
            chk("user_cfg", user_io_enable_o, 1'b0);
            chk("pullup_cfg", weak_pullup_en_o, k != 3);
            pulse(0);
            chk("init_oe", init_done_oe_o, 1'b1);
            if (code[1]) begin
                host.shift(8'hA5);
                rd(REG_SHIFT, d);
                chk("shift", d, 32'h000800A5);
            end
            pulse(1);
            chk("done_set", config_done_out_o, 1'b1);
            d = 32'h0;
            while (user_io_enable_o !== 1'b1 && d < 32'h64) begin
                cyc(1);
                d++;
            end
            chk("init_len", d, INIT_CYCLES);
            chk("pullup_user", weak_pullup_en_o, 1'b0);
            chk("init_rel", init_done_oe_o, 1'b0);
            chk("user_mode", user_mode_o, 1'b1);
            host.start(~code, 1'b0, 1'b0);
            cyc(6);
            chk("scheme_hold", scheme_o, code);
            host.stop();
            cyc(6);
            chk("done_req", config_done_out_o, 1'b0);
            chk("user_req", user_io_enable_o, 1'b0);
        end
        wr(REG_CTRL, 32'h1);
        wr(REG_IRQ_MASK, 32'h0);
        host.start(SCH_SERIAL, 1'b0, 1'b0);
        wait_st(CMP_CONFIG);
        pulse(2);
        chk("err_status", config_status_n_oe_o, 1'b1);
        chk("err_done", config_done_out_o, 1'b0);
        chk("irq_masked", irq_o, 1'b0);
        wr(REG_IRQ_MASK, 32'h4);
        cyc(1);
        chk("irq_set", irq_o, 1'b1);
        wait_st(CMP_CONFIG);
        wr(REG_IRQ_STAT, 32'h4);
        rd(REG_IRQ_STAT, d);
        chk("irq_clr", d[2], 1'b0);
        chk("irq_low", irq_o, 1'b0);
        wr(REG_CTRL, 32'h0);
        host.stop();
        cyc(6);
        host.start(3'h3, 1'b0, 1'b0);
        wait_st(CMP_ERROR);
        chk("illegal", config_status_n_oe_o, 1'b1);
        host.stop();
        cyc(6);
        host.start(3'h7, 1'b1, 1'b1);
        wait_st(CMP_CONFIG);
        chk("jtag", jtag_mode_o, 1'b1);
        chk("jtag_rl", remote_update_o, 1'b0);
        close_out();
    end
endmodule // cmp_config_ctrl_test

// [test/cmp_host_model.sv]
// model of the configuration host: scheme pins, request, boundary-scan start, serial stream
// assumes its tasks are called one at a time from the bench's main process
`timescale 1ns/1ps
module cmp_host_model (
    input wire logic clk_i,
    output logic [2:0] scheme_select_o,
    output logic remote_local_select_o,
    output logic config_request_n_o,
    output logic jtag_config_o,
    output logic config_clock_o,
    output logic serial_config_data_o
);
    // every pin at a defined level from time zero
    // request held low until a cycle is started, so the device leaves reset first
    initial begin
        scheme_select_o = 3'h0;
        remote_local_select_o = 1'b0;
        config_request_n_o = 1'b0;
        jtag_config_o = 1'b0;
        config_clock_o = 1'b0;
        serial_config_data_o = 1'b0;
    end
    // pins change together so one consistent scheme is sampled
    task automatic start(input logic [2:0] code, input logic rem, input logic jt);
        @(posedge clk_i);
        scheme_select_o <= code;
        remote_local_select_o <= rem;
        jtag_config_o <= jt;
        config_request_n_o <= 1'b1;
    endtask
    task automatic stop();
        @(posedge clk_i);
        config_request_n_o <= 1'b0;
        jtag_config_o <= 1'b0;
    endtask
    // msb first, slow clock resting low between frames
    task automatic shift(input logic [7:0] b);
        int i;
        for (i = 7; i >= 0; i--) begin
            @(posedge clk_i);
            serial_config_data_o <= b[i];
            repeat (3) @(posedge clk_i);
            config_clock_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            config_clock_o <= 1'b0;
        end
        // a held line would hide a late sample, so it flips after the frame
        @(posedge clk_i);
        serial_config_data_o <= ~b[0];
    endtask
endmodule // cmp_host_model
